//--- src/fbsx_exec.sv
// four-phase execute slice for flag branches, branch always and bit set
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/100ps
// What this block does
// - opcode E7: branch only when negative flag clear, else fall through
// - opcode E5: branch only when overflow flag clear, else fall through
// - opcode E1: branch only when zero flag clear, else fall through
// - opcode E3: branch only when carry flag clear, else fall through
// - conditional taken target is incremented pc plus twice signed 8-bit offset
// - not taken costs one cycle; taken writes pc in Q4 then one nop cycle
// - top nibble D, bit 11 clear: always branch, 11-bit offset, two cycles
// - top nibble 8: read register, force chosen bit high, write back
// - access bit zero uses fixed bank; one uses bank select register
// - none of these instructions change any status flag
module fbsx_exec
	import fbsx_pkg::*;
#(
	parameter int PC_W = 21,
	parameter int BANK_W = 4,
	parameter logic [3:0] ACCESS_BANK = 4'h0
) (
	input wire logic clk,
	input wire logic reset,
	// apb register port
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// instruction and core state
	input wire logic instr_valid,
	input wire logic [15:0] instr,
	input wire logic [PC_W-1:0] pc_incr,
	input wire logic flag_n,
	input wire logic flag_ov,
	input wire logic flag_z,
	input wire logic flag_c,
	output fbsx_pkg::fbsx_phase_t q_phase,
	output logic instr_hit,
	output logic nop_cycle,
	output logic pc_load,
	output logic [PC_W-1:0] pc_target,
	// banked data memory
	output logic [BANK_W+7:0] dmem_addr,
	output logic dmem_re,
	input wire logic [7:0] dmem_rdata,
	output logic dmem_we,
	output logic [7:0] dmem_wdata
);
	import fbsx_pkg::*;

	// ==========================================================
	// state
	fbsx_phase_t phase;
	fbsx_phase_t next_phase;
	fbsx_kind_t kind;
	fbsx_kind_t next_kind;
	logic [15:0] ir;
	logic exec_en;
	logic [BANK_W-1:0] bank_select_register;
	logic [15:0] taken_cnt;
	logic pend_nop;

	// ==========================================================
	// decode of the incoming word
	wire logic hi_nn, hi_nov, hi_nz, hi_nc, is_cond, is_always, is_bitset;
	wire logic take_q1;
	assign hi_nn = instr[15:8] == FBSX_OP_NOT_NEG;
	assign hi_nov = instr[15:8] == FBSX_OP_NO_OVF;
	assign hi_nz = instr[15:8] == FBSX_OP_NOT_ZERO;
	assign hi_nc = instr[15:8] == FBSX_OP_NO_CARRY;
	assign is_cond = hi_nn | hi_nov | hi_nz | hi_nc;
	assign is_always = (instr[15:12] == FBSX_OP_ALWAYS) & ~instr[11];
	assign is_bitset = instr[15:12] == FBSX_OP_BITSET;
	// a valid word is taken at Q1 while exec_en is set, unless the slot is the nop after a branch
	assign take_q1 = (phase == FBSX_Q1) & instr_valid & exec_en & ~pend_nop;
	assign instr_hit = take_q1 & (is_cond | is_always | is_bitset);

	always_comb begin
		next_kind = FBSX_K_NONE;
		if (is_cond)
			next_kind = FBSX_K_COND;
		else if (is_always)
			next_kind = FBSX_K_ALWAYS;
		else if (is_bitset)
			next_kind = FBSX_K_BITSET;
	end

	// ==========================================================
	// phase sequencer, one instruction cycle is four clocks
	always_comb begin
		case (phase)
			FBSX_Q1: next_phase = FBSX_Q2;
			FBSX_Q2: next_phase = FBSX_Q3;
			FBSX_Q3: next_phase = FBSX_Q4;
			FBSX_Q4: next_phase = FBSX_Q1;
			default: next_phase = FBSX_Q1;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			phase <= FBSX_Q1;
		else
			phase <= next_phase;
	end
	assign q_phase = phase;

	// latch the instruction at the Q1 edge, drop it after Q4
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ir <= 16'h0000;
			kind <= FBSX_K_NONE;
		end else if (take_q1) begin
			ir <= instr;
			kind <= next_kind;
		end else if (phase == FBSX_Q4) begin
			kind <= FBSX_K_NONE;
		end
	end

	// ==========================================================
	// branch condition, flags are only read here
	wire logic cond_true, br_taken;
	assign cond_true = (ir[15:8] == FBSX_OP_NOT_NEG) ? ~flag_n :
		(ir[15:8] == FBSX_OP_NO_OVF) ? ~flag_ov :
		(ir[15:8] == FBSX_OP_NOT_ZERO) ? ~flag_z :
		~flag_c;
	assign br_taken = (kind == FBSX_K_ALWAYS) |
		((kind == FBSX_K_COND) & cond_true);

	wire logic [PC_W-1:0] tgt_cond, tgt_alw;
	fbsx_target #(.PC_W(PC_W), .OFF_W(FBSX_COND_OFF_W)) u_tgt_cond (
		.pc_incr(pc_incr),
		.offset(ir[7:0]),
		.target(tgt_cond)
	);
	fbsx_target #(.PC_W(PC_W), .OFF_W(FBSX_ALW_OFF_W)) u_tgt_alw (
		.pc_incr(pc_incr),
		.offset(ir[10:0]),
		.target(tgt_alw)
	);

	// pc is written during Q4 of a taken branch
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pc_load <= 1'b0;
			pc_target <= '0;
		end else begin
			pc_load <= (phase == FBSX_Q3) & br_taken;
			if ((phase == FBSX_Q3) & br_taken)
				pc_target <= (kind == FBSX_K_ALWAYS) ? tgt_alw : tgt_cond;
		end
	end

	// second cycle of a taken branch does nothing
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			pend_nop <= 1'b0;
		else if (phase == FBSX_Q4)
			pend_nop <= pc_load;
	end
	assign nop_cycle = pend_nop;

	// ==========================================================
	// bit set: address and read strobe in Q2, read data taken in Q3, write back in Q4
	wire logic [BANK_W+7:0] bs_addr;
	wire logic [7:0] bs_data;
	fbsx_bitset #(.BANK_W(BANK_W), .ACCESS_BANK(ACCESS_BANK)) u_bitset (
		.reg_addr(instr[7:0]),
		.access_sel(instr[8]),
		.bank_sel(bank_select_register),
		.bit_index(ir[11:9]),
		.data_in(dmem_rdata),
		.mem_addr(bs_addr),
		.data_out(bs_data)
	);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dmem_addr <= '0;
			dmem_re <= 1'b0;
			dmem_we <= 1'b0;
			dmem_wdata <= 8'h00;
		end else begin
			if (take_q1 & is_bitset)
				dmem_addr <= bs_addr;
			dmem_re <= take_q1 & is_bitset;
			dmem_we <= (phase == FBSX_Q3) & (kind == FBSX_K_BITSET);
			if ((phase == FBSX_Q3) & (kind == FBSX_K_BITSET))
				dmem_wdata <= bs_data;
		end
	end

	// ==========================================================
	// apb slave, zero wait states
	wire logic wr_acc, rd_setup, hit_ctrl, hit_bank, hit_stat, hit_tcnt;
	wire logic addr_hit, cnt_inc, cnt_clr;
	wire logic [31:0] rd_mux;
	assign hit_ctrl = paddr == FBSX_CTRL_OFF;
	assign hit_bank = paddr == FBSX_BANK_OFF;
	assign hit_stat = paddr == FBSX_STAT_OFF;
	assign hit_tcnt = paddr == FBSX_TCNT_OFF;
	assign addr_hit = hit_ctrl | hit_bank | hit_stat | hit_tcnt;
	assign wr_acc = psel & penable & pwrite & addr_hit;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pready = psel & penable;
	assign pslverr = psel & penable & ~addr_hit;
	assign rd_mux = hit_ctrl ? {31'h0, exec_en} :
		hit_bank ? {{(32-BANK_W){1'b0}}, bank_select_register} :
		hit_stat ? {26'h0, phase, 2'h0, kind != FBSX_K_NONE, pend_nop} :
		hit_tcnt ? {16'h0, taken_cnt} : 32'h0;
	assign cnt_inc = pc_load;
	assign cnt_clr = wr_acc & hit_tcnt;

	// read data is captured in the setup cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			prdata <= 32'h0;
		else if (rd_setup)
			prdata <= rd_mux;
	end

	// control and bank registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			exec_en <= FBSX_CTRL_EN_RST;
			bank_select_register <= FBSX_BANK_RST[BANK_W-1:0];
		end else begin
			if (wr_acc & hit_ctrl)
				exec_en <= pwdata[FBSX_CTRL_EN_BIT];
			if (wr_acc & hit_bank)
				bank_select_register <= pwdata[BANK_W-1:0];
		end
	end

	// taken branch counter, a clear with a count in the same cycle leaves it at one
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			taken_cnt <= FBSX_TCNT_RST;
		else if (cnt_clr)
			taken_cnt <= cnt_inc ? 16'h0001 : 16'h0000;
		else if (cnt_inc)
			taken_cnt <= taken_cnt + 16'h0001;
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	logic [PC_W-1:0] chk_cond_tgt;
	assign chk_cond_tgt = pc_incr + {{(PC_W-9){ir[7]}}, ir[7:0], 1'b0};

	a_not_neg_branch: assert property (
		(phase == FBSX_Q3 && kind == FBSX_K_COND
			&& ir[15:8] == FBSX_OP_NOT_NEG) |=> pc_load == !$past(flag_n))
		else $error("negative-clear branch decision wrong");
	a_no_ovf_branch: assert property (
		(phase == FBSX_Q3 && kind == FBSX_K_COND
			&& ir[15:8] == FBSX_OP_NO_OVF) |=> pc_load == !$past(flag_ov))
		else $error("overflow-clear branch decision wrong");
	a_not_zero_branch: assert property (
		(phase == FBSX_Q3 && kind == FBSX_K_COND
			&& ir[15:8] == FBSX_OP_NOT_ZERO) |=> pc_load == !$past(flag_z))
		else $error("zero-clear branch decision wrong");
	a_no_carry_branch: assert property (
		(phase == FBSX_Q3 && kind == FBSX_K_COND
			&& ir[15:8] == FBSX_OP_NO_CARRY) |=> pc_load == !$past(flag_c))
		else $error("carry-clear branch decision wrong");
	a_cond_target_value: assert property (
		(phase == FBSX_Q3 && kind == FBSX_K_COND && cond_true)
			|=> pc_target == $past(chk_cond_tgt))
		else $error("conditional target wrong");
	a_taken_nop_cycle: assert property (
		pc_load |-> q_phase == FBSX_Q4 ##1 nop_cycle [*4] ##1 !nop_cycle)
		else $error("taken branch nop cycle wrong");
	a_untaken_no_nop: assert property (
		(phase == FBSX_Q4 && kind == FBSX_K_COND && !pc_load)
			|=> !nop_cycle [*4])
		else $error("untaken branch stalled");
	a_always_taken: assert property (
		(phase == FBSX_Q3 && kind == FBSX_K_ALWAYS) |=> pc_load
			&& pc_target == $past(pc_incr)
			+ {{(PC_W-12){ir[10]}}, ir[10:0], 1'b0})
		else $error("branch always not taken correctly");
	a_bitset_write: assert property (
		dmem_we |-> dmem_wdata == ($past(dmem_rdata) | (8'h01 << ir[11:9]))
			&& $past(dmem_re, 2))
		else $error("bit set write-back wrong");
	a_access_bank: assert property (
		(take_q1 && is_bitset && !instr[8])
			|=> dmem_re && dmem_addr[BANK_W+7:8] == ACCESS_BANK[BANK_W-1:0])
		else $error("access bank not used");
	a_bank_select: assert property (
		(take_q1 && is_bitset && instr[8])
			|=> dmem_addr[BANK_W+7:8] == $past(bank_select_register))
		else $error("bank select register not used");
endmodule // fbsx_exec

//--- src/fbsx_pkg.sv
// shared constants and types for the branch and bit-set execute slice
package fbsx_pkg;
	// ==========================================================
	// register map (byte addresses on the apb port)
	localparam logic [7:0] FBSX_CTRL_OFF = 8'h00;
	localparam logic [7:0] FBSX_BANK_OFF = 8'h04;
	localparam logic [7:0] FBSX_STAT_OFF = 8'h08;
	localparam logic [7:0] FBSX_TCNT_OFF = 8'h0C;
	localparam int FBSX_CTRL_EN_BIT = 0;
	localparam int FBSX_STAT_NOP_BIT = 0;
	localparam int FBSX_STAT_BUSY_BIT = 1;
	localparam int FBSX_STAT_PH_LSB = 4;
	localparam logic FBSX_CTRL_EN_RST = 1'b1;
	localparam logic [3:0] FBSX_BANK_RST = 4'h0;
	localparam logic [15:0] FBSX_TCNT_RST = 16'h0000;
	// ==========================================================
	// opcode fields
	localparam logic [7:0] FBSX_OP_NOT_NEG = 8'hE7;
	localparam logic [7:0] FBSX_OP_NO_OVF = 8'hE5;
	localparam logic [7:0] FBSX_OP_NOT_ZERO = 8'hE1;
	localparam logic [7:0] FBSX_OP_NO_CARRY = 8'hE3;
	localparam logic [3:0] FBSX_OP_ALWAYS = 4'hD;
	localparam logic [3:0] FBSX_OP_BITSET = 4'h8;
	localparam int FBSX_COND_OFF_W = 8;
	localparam int FBSX_ALW_OFF_W = 11;
	// ==========================================================
	// types
	typedef enum logic [1:0] {FBSX_Q1, FBSX_Q2, FBSX_Q3, FBSX_Q4} fbsx_phase_t;
	typedef enum logic [1:0] {
		FBSX_K_NONE, FBSX_K_COND, FBSX_K_ALWAYS, FBSX_K_BITSET
	} fbsx_kind_t;
endpackage

//--- src/fbsx_target.sv
// relative branch target adder: incremented pc plus twice a signed offset
`timescale 1ns/100ps
module fbsx_target #(
	parameter int PC_W = 21,
	parameter int OFF_W = 8
) (
	input wire logic [PC_W-1:0] pc_incr,
	input wire logic [OFF_W-1:0] offset,
	output logic [PC_W-1:0] target
);
	wire logic [PC_W-1:0] ext_off;
	wire logic [PC_W-1:0] dbl_off;
	// sign extend, then double; the sum wraps in pc width
	assign ext_off = {{(PC_W-OFF_W){offset[OFF_W-1]}}, offset};
	assign dbl_off = {ext_off[PC_W-2:0], 1'b0};
	assign target = pc_incr + dbl_off;
endmodule // fbsx_target

//--- src/fbsx_bitset.sv
// bit-set data path: banked address forming and single bit force
`timescale 1ns/100ps
module fbsx_bitset #(
	parameter int BANK_W = 4,
	parameter logic [3:0] ACCESS_BANK = 4'h0
) (
	input wire logic [7:0] reg_addr,
	input wire logic access_sel,
	input wire logic [BANK_W-1:0] bank_sel,
	input wire logic [2:0] bit_index,
	input wire logic [7:0] data_in,
	output logic [BANK_W+7:0] mem_addr,
	output logic [7:0] data_out
);
	wire logic [BANK_W-1:0] bank_used;
	// access select low ignores the bank select register
	assign bank_used = access_sel ? bank_sel : ACCESS_BANK[BANK_W-1:0];
	assign mem_addr = {bank_used, reg_addr};
	// only the chosen bit is forced high
	assign data_out = data_in | (8'h01 << bit_index);
endmodule // fbsx_bitset

//--- bench/fbsx_exec_tb.sv
// self-checking bench for the branch and bit-set execute slice
`timescale 1ns/100ps
module fbsx_exec_tb;
	import fbsx_pkg::*;
	localparam int PW = 21;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic instr_valid = 1'b0;
	logic [15:0] instr = 16'h0;
	logic [PW-1:0] pc_incr = '0;
	logic [3:0] fl = 4'h0;
	logic [7:0] dmem_rdata = 8'h00;
	logic [31:0] prdata;
	logic pready, pslverr, instr_hit, nop_cycle, pc_load, dmem_re, dmem_we;
	fbsx_phase_t q_phase;
	logic [PW-1:0] pc_target;
	logic [11:0] dmem_addr;
	logic [7:0] dmem_wdata;
	int num_errors = 0;
	int n_checks = 0;
	// ==========================================================
	// clock, device under test
	always #4 clk = ~clk;
	fbsx_exec fbsx_exec_inst (
		.clk(clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .instr_valid(instr_valid),
		.instr(instr), .pc_incr(pc_incr), .flag_n(fl[3]), .flag_ov(fl[2]),
		.flag_z(fl[1]), .flag_c(fl[0]), .q_phase(q_phase),
		.instr_hit(instr_hit), .nop_cycle(nop_cycle), .pc_load(pc_load),
		.pc_target(pc_target), .dmem_addr(dmem_addr), .dmem_re(dmem_re),
		.dmem_rdata(dmem_rdata), .dmem_we(dmem_we), .dmem_wdata(dmem_wdata)
	);
	// ==========================================================
	// helpers
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// expected target: incremented pc plus twice the sign-extended offset
	function logic [PW-1:0] tg(input logic [PW-1:0] pc, input logic [10:0] o);
		return pc + {{(PW-12){o[10]}}, o, 1'b0};
	endfunction
	// one apb transfer, held until pready is seen high at an edge
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// no wait count is assumed; only the watchdog ends a hang
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// issue one word in a Q1 cycle and watch the four phases that follow
	task exec(input logic [15:0] w, input logic [3:0] f,
		input logic [PW-1:0] pc, input logic eh, input logic el,
		input logic [PW-1:0] et, input logic er, input logic [11:0] ea,
		input logic [7:0] ew);
		#1;
		while (q_phase !== FBSX_Q4) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		instr <= w;
		instr_valid <= 1'b1;
		fl <= f;
		pc_incr <= pc;
		#1;
		chk(instr_hit, eh, "accept");
		@(posedge clk);
		instr_valid <= 1'b0;
		#1;
		chk(dmem_re, er, "read strobe");
		if (er) chk(dmem_addr, ea, "bank address");
		repeat (2) @(posedge clk);
		#1;
		chk(pc_load, el, "pc load");
		if (el) chk(pc_target, et, "target");
		chk(dmem_we, er, "write strobe");
		if (er) chk(dmem_wdata, ew, "write data");
		// a taken branch turns the next slot into a nop that refuses words
		if (el) begin
			@(posedge clk);
			instr_valid <= 1'b1;
			#1;
			chk(nop_cycle, 1'b1, "nop cycle");
			chk(instr_hit, 1'b0, "nop refuse");
			@(posedge clk);
			instr_valid <= 1'b0;
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ==========================================================
	// main sequence
	initial begin
		logic [31:0] rd;
		logic err;
		logic [7:0] ops [4];
		logic [7:0] off;
		logic [3:0] m;
		logic [7:0] rv;
		logic [7:0] fa;
		logic tk;
		int k;
		ops = '{FBSX_OP_NOT_NEG, FBSX_OP_NO_OVF, FBSX_OP_NOT_ZERO,
			FBSX_OP_NO_CARRY};
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		apb(1'b0, FBSX_CTRL_OFF, 32'h0, rd, err);
		chk(rd, 32'h1, "ctrl reset");
		apb(1'b0, FBSX_TCNT_OFF, 32'h0, rd, err);
		chk(rd, 32'h0, "count reset");
		apb(1'b1, 8'h10, 32'hFFFFFFFF, rd, err);
		chk(err, 1'b1, "unmapped");
		apb(1'b1, FBSX_BANK_OFF, 32'h5, rd, err);
		apb(1'b0, FBSX_BANK_OFF, 32'h0, rd, err);
		chk(rd, 32'h5, "bank readback");
		// idle status: no nop slot, nothing in flight; phase bits masked
		apb(1'b0, FBSX_STAT_OFF, 32'h0, rd, err);
		chk(rd & 32'hFFFFFFCF, 32'h0, "status idle");
		chk(err, 1'b0, "mapped no error");
		$display("test registers done");
		// each flag opcode taken with only its flag clear, then not taken
		for (int i = 0; i < 8; i++) begin
			k = i / 2;
			m = 4'h8 >> k;
			tk = ~i[0];
			off = k[0] ? 8'h7F : 8'h80;
			exec({ops[k], off}, tk ? ~m : m, 21'h1000, 1'b1, tk,
				tg(21'h1000, {{3{off[7]}}, off}), 1'b0, 12'h0, 8'h0);
		end
		apb(1'b0, FBSX_TCNT_OFF, 32'h0, rd, err);
		chk(rd, 32'h4, "taken count");
		// any write to the count offset clears the taken counter
		apb(1'b1, FBSX_TCNT_OFF, 32'hFFFFFFFF, rd, err);
		apb(1'b0, FBSX_TCNT_OFF, 32'h0, rd, err);
		chk(rd, 32'h0, "count clear");
		$display("test conditional done");
		exec(16'hD400, 4'hF, 21'h1000, 1'b1, 1'b1,
			tg(21'h1000, 11'h400), 1'b0, 12'h0, 8'h0);
		exec(16'hD3FF, 4'h0, 21'h1000, 1'b1, 1'b1,
			tg(21'h1000, 11'h3FF), 1'b0, 12'h0, 8'h0);
		exec(16'hD7FF, 4'h0, 21'h0, 1'b1, 1'b1,
			21'h1FFFFE, 1'b0, 12'h0, 8'h0);
		exec(16'hE1FF, 4'h0, 21'h0, 1'b1, 1'b1,
			21'h1FFFFE, 1'b0, 12'h0, 8'h0);
		exec(16'hD800, 4'h0, 21'h1000, 1'b0, 1'b0,
			21'h0, 1'b0, 12'h0, 8'h0);
		$display("test branch always done");
		// disabled slice ignores a branch that would be taken
		apb(1'b1, FBSX_CTRL_OFF, 32'h0, rd, err);
		exec(16'hE700, 4'h0, 21'h1000, 1'b0, 1'b0, 21'h0, 1'b0, 12'h0, 8'h0);
		apb(1'b1, FBSX_CTRL_OFF, 32'h1, rd, err);
		$display("test enable done");
		// every bit index, both bank choices, bank register holds 5
		for (int b = 0; b < 8; b++) begin
			rv = 8'h5A & ~(8'h01 << b);
			fa = 8'hFF - b[7:0];
			@(posedge clk);
			dmem_rdata <= rv;
			exec({4'h8, b[2:0], b[0], fa}, 4'hF, 21'h1000, 1'b1, 1'b0,
				21'h0, 1'b1, {b[0] ? 4'h5 : 4'h0, fa},
				rv | (8'h01 << b));
		end
		$display("test bit set done");
		test_done;
	end
	// ==========================================================
	// watchdog against a hung handshake
	initial begin
		#100000;
		num_errors++;
		$display("BAD t=%0t watchdog expired", $time);
		test_done;
	end
endmodule // fbsx_exec_tb
